// *** common/acc_consts.svh ***
// Register offsets, reset values and timing counts of the calibration coefficient block.
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH
`define ACC_OFS_TEMP_OFFSET 32'hFFFF0538
`define ACC_OFS_CUR_GAIN 32'hFFFF053C
`define ACC_OFS_MODE 32'hFFFF0560
`define ACC_OFS_STATUS 32'hFFFF0564
`define ACC_MODE_ENABLE_BIT 0
`define ACC_MODE_LSB 1
`define ACC_MODE_MSB 2
`define ACC_RST_MODE 3'h0
`define ACC_IDLE_TIME_NS 23000
`define ACC_CLK_PERIOD_NS 5
`define ACC_IDLE_CYCLES ((`ACC_IDLE_TIME_NS + `ACC_CLK_PERIOD_NS - 1) / `ACC_CLK_PERIOD_NS)
`define ACC_CAL_CYCLES 16
`endif

// *** common/acc_pkg.sv ***
// Types shared by the calibration coefficient block.
package acc_pkg;
   typedef enum logic [1:0] {
      ACC_MODE_IDLE = 2'h0,
      ACC_MODE_RUN = 2'h1,
      ACC_MODE_CAL_TOFS = 2'h2,
      ACC_MODE_CAL_IGAIN = 2'h3
   } acc_mode_type;
   typedef enum logic [2:0] {
      ACC_ST_IDLE = 3'h1,
      ACC_ST_RUN = 3'h2,
      ACC_ST_CAL = 3'h4
   } acc_state_type;
endpackage

// *** hw/acc_coef_reg.sv ***
// One 16-bit calibration coefficient with factory default, calibration load and gated write.
`timescale 1ns/10ps
`include "acc_consts.svh"
module acc_coef_reg #(
   parameter int WIDTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] factory_value,
   input wire logic load_default,
   input wire logic cal_load,
   input wire logic [WIDTH-1:0] cal_value,
   input wire logic sw_write,
   input wire logic [WIDTH-1:0] sw_value,
   output logic [WIDTH-1:0] coef
);
   logic [WIDTH-1:0] next_coef;

   if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
      $error("acc_coef_reg: WIDTH out of range");
   end

   always_comb begin
      next_coef = coef;
      if (load_default) begin
         next_coef = factory_value;
      end else if (cal_load) begin
         next_coef = cal_value;
      end else if (sw_write) begin
         next_coef = sw_value;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         coef <= '0;
      end else begin
         coef <= next_coef;
      end
   end
endmodule

// *** hw/acc_calib_regs.sv ***
// AHB-Lite register block holding temperature offset and current gain calibration coefficients.
//
// Functional notes
// - Keep a 16-bit temperature channel offset coefficient, applied to its conversions.
// - Keep a 16-bit current channel gain coefficient scaling each result.
// - Load both coefficients with factory defaults at power-on.
// - Temperature offset calibration started via mode register overwrites the offset coefficient.
// - Current gain calibration started via mode register overwrites the gain coefficient.
`timescale 1ns/10ps
`include "acc_consts.svh"
module acc_calib_regs #(
   parameter int IDLE_CYCLES = `ACC_IDLE_CYCLES,
   parameter int CAL_CYCLES = `ACC_CAL_CYCLES,
   parameter logic [15:0] TEMP_OFFSET_FACTORY = 16'h8000,
   parameter logic [15:0] CUR_GAIN_FACTORY = 16'h5555
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic [15:0] TEMP_CAL_RESULT,
   input wire logic [15:0] CUR_CAL_RESULT,
   input wire logic [15:0] TEMP_RAW,
   input wire logic [15:0] CUR_RAW,
   output logic [15:0] TEMP_OFFSET_COEF,
   output logic [15:0] CUR_GAIN_COEF,
   output logic [15:0] TEMP_CORRECTED,
   output logic [15:0] CUR_SCALED
);
   ////////////////////////////////////////////////////////////////////////////////
   // The idle and calibration timers are 16 bits wide, so larger counts cannot be served.
   if (IDLE_CYCLES < 1 || IDLE_CYCLES > 65535) begin : g_bad_idle
      $error("acc_calib_regs: bad IDLE_CYCLES");
   end
   if (CAL_CYCLES < 1 || CAL_CYCLES > 65535) begin : g_bad_cal
      $error("acc_calib_regs: bad CAL_CYCLES");
   end

   logic wr_pend, next_wr_pend;
   logic [31:0] wr_addr, next_wr_addr;
   logic [31:0] rdata, next_rdata;
   logic [2:0] mode_reg, next_mode_reg;
   acc_pkg::acc_state_type state, next_state;
   logic [15:0] idle_cnt, next_idle_cnt;
   logic [15:0] cal_cnt, next_cal_cnt;
   logic cal_is_gain, next_cal_is_gain;
   logic por_done, next_por_done;
   logic [15:0] temp_coef, cur_coef;
   logic [15:0] temp_out, next_temp_out, cur_out, next_cur_out;
   logic [15:0] temp_corr, next_temp_corr, cur_scl, next_cur_scl;
   logic [31:0] cur_product;
   logic addr_phase, write_ok, idle_ready, wr_temp, wr_cur;
   logic cal_tofs_done, cal_igain_done;
   acc_pkg::acc_mode_type mode_field;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus slave: every transfer completes with no wait state and OKAY.
   assign addr_phase = HSEL && HREADY && HTRANS[1];
   assign mode_field = acc_pkg::acc_mode_type'(mode_reg[`ACC_MODE_MSB:`ACC_MODE_LSB]);
   assign idle_ready = (idle_cnt >= 16'(IDLE_CYCLES));
   // The gate is checked when the data arrive, so it holds for the cycle the value lands.
   assign write_ok = mode_reg[`ACC_MODE_ENABLE_BIT] && (state == acc_pkg::ACC_ST_IDLE)
                     && idle_ready;
   assign wr_temp = wr_pend && (wr_addr == `ACC_OFS_TEMP_OFFSET) && write_ok;
   assign wr_cur = wr_pend && (wr_addr == `ACC_OFS_CUR_GAIN) && write_ok;

   always_comb begin
      next_wr_pend = addr_phase && HWRITE;
      next_wr_addr = addr_phase ? HADDR : wr_addr;
      next_rdata = rdata;
      if (addr_phase && !HWRITE) begin
         case (HADDR)
            `ACC_OFS_TEMP_OFFSET: next_rdata = {16'h0000, temp_coef};
            `ACC_OFS_CUR_GAIN: next_rdata = {16'h0000, cur_coef};
            `ACC_OFS_MODE: next_rdata = {29'h0, mode_reg};
            `ACC_OFS_STATUS: next_rdata = {16'h0000, idle_cnt[15:3], state};
            default: next_rdata = 32'h00000000;
         endcase
      end
      next_mode_reg = mode_reg;
      if (wr_pend && wr_addr == `ACC_OFS_MODE) begin
         next_mode_reg = HWDATA[2:0];
      end else if (cal_tofs_done || cal_igain_done) begin
         // A finished calibration returns the converter to idle, as software expects.
         next_mode_reg = {mode_reg[2] & 1'b0, 1'b0, mode_reg[0]};
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         wr_pend <= 1'b0;
         wr_addr <= 32'h00000000;
         rdata <= 32'h00000000;
         mode_reg <= `ACC_RST_MODE;
      end else begin
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         rdata <= next_rdata;
         mode_reg <= next_mode_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Converter sequencer: idle timer and calibration runs.
   always_comb begin
      next_state = state;
      next_idle_cnt = idle_cnt;
      next_cal_cnt = cal_cnt;
      next_cal_is_gain = cal_is_gain;
      cal_tofs_done = 1'b0;
      cal_igain_done = 1'b0;
      case (state)
         acc_pkg::ACC_ST_IDLE: begin
            if (!mode_reg[`ACC_MODE_ENABLE_BIT]) begin
               next_idle_cnt = 16'h0000;
            end else if (mode_field == acc_pkg::ACC_MODE_IDLE) begin
               if (!idle_ready) next_idle_cnt = idle_cnt + 16'h0001;
            end else if (mode_field == acc_pkg::ACC_MODE_RUN) begin
               next_state = acc_pkg::ACC_ST_RUN;
               next_idle_cnt = 16'h0000;
            end else begin
               next_state = acc_pkg::ACC_ST_CAL;
               next_cal_cnt = 16'h0000;
               next_idle_cnt = 16'h0000;
               next_cal_is_gain = (mode_field == acc_pkg::ACC_MODE_CAL_IGAIN);
            end
         end
         acc_pkg::ACC_ST_RUN: begin
            if (!mode_reg[`ACC_MODE_ENABLE_BIT] || mode_field != acc_pkg::ACC_MODE_RUN) begin
               next_state = acc_pkg::ACC_ST_IDLE;
               next_idle_cnt = 16'h0000;
            end
         end
         acc_pkg::ACC_ST_CAL: begin
            if (!mode_reg[`ACC_MODE_ENABLE_BIT]) begin
               next_state = acc_pkg::ACC_ST_IDLE;
            end else if (cal_cnt == 16'(CAL_CYCLES - 1)) begin
               cal_tofs_done = !cal_is_gain;
               cal_igain_done = cal_is_gain;
               next_state = acc_pkg::ACC_ST_IDLE;
               next_idle_cnt = 16'h0000;
            end else begin
               next_cal_cnt = cal_cnt + 16'h0001;
            end
         end
         default: begin
            next_state = acc_pkg::ACC_ST_IDLE;
            next_idle_cnt = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state <= acc_pkg::ACC_ST_IDLE;
         idle_cnt <= 16'h0000;
         cal_cnt <= 16'h0000;
         cal_is_gain <= 1'b0;
      end else begin
         state <= next_state;
         idle_cnt <= next_idle_cnt;
         cal_cnt <= next_cal_cnt;
         cal_is_gain <= next_cal_is_gain;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Coefficients. Factory values land in the first cycle after reset release.
   always_comb begin
      next_por_done = 1'b1;
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         por_done <= 1'b0;
      end else begin
         por_done <= next_por_done;
      end
   end

   acc_coef_reg #(.WIDTH(16)) u_temp_offset (
      .clk(CLK),
      .rst_n(RST_N),
      .factory_value(TEMP_OFFSET_FACTORY),
      .load_default(!por_done),
      .cal_load(cal_tofs_done),
      .cal_value(TEMP_CAL_RESULT),
      .sw_write(wr_temp),
      .sw_value(HWDATA[15:0]),
      .coef(temp_coef)
   );

   acc_coef_reg #(.WIDTH(16)) u_cur_gain (
      .clk(CLK),
      .rst_n(RST_N),
      .factory_value(CUR_GAIN_FACTORY),
      .load_default(!por_done),
      .cal_load(cal_igain_done),
      .cal_value(CUR_CAL_RESULT),
      .sw_write(wr_cur),
      .sw_value(HWDATA[15:0]),
      .coef(cur_coef)
   );

   // Gain is unsigned Q1.15; results saturate rather than wrap.
   assign cur_product = CUR_RAW * cur_coef;

   always_comb begin
      next_temp_out = temp_coef;
      next_cur_out = cur_coef;
      next_temp_corr = TEMP_RAW - (temp_coef - 16'h8000);
      next_cur_scl = (cur_product[31]) ? 16'hFFFF : cur_product[30:15];
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         temp_out <= 16'h0000;
         cur_out <= 16'h0000;
         temp_corr <= 16'h0000;
         cur_scl <= 16'h0000;
      end else begin
         temp_out <= next_temp_out;
         cur_out <= next_cur_out;
         temp_corr <= next_temp_corr;
         cur_scl <= next_cur_scl;
      end
   end

   assign TEMP_OFFSET_COEF = temp_out;
   assign CUR_GAIN_COEF = cur_out;
   assign TEMP_CORRECTED = temp_corr;
   assign CUR_SCALED = cur_scl;
   assign HRDATA = rdata;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.
   sequence s_cal_end;
      state == acc_pkg::ACC_ST_CAL && cal_cnt == 16'(CAL_CYCLES - 1) && mode_reg[0];
   endsequence

   property p_temp_cal;
      @(posedge CLK) disable iff (!RST_N)
         (s_cal_end and !cal_is_gain && por_done) |=> temp_coef == $past(TEMP_CAL_RESULT);
   endproperty
   a_temp_cal: assert property (p_temp_cal) else $error("offset not calibrated");

   property p_gain_cal;
      @(posedge CLK) disable iff (!RST_N)
         (s_cal_end and cal_is_gain && por_done) |=> cur_coef == $past(CUR_CAL_RESULT);
   endproperty
   a_gain_cal: assert property (p_gain_cal) else $error("gain not calibrated");

   property p_por_default;
      @(posedge CLK) $rose(RST_N) |=> temp_coef == TEMP_OFFSET_FACTORY
                                      && cur_coef == CUR_GAIN_FACTORY;
   endproperty
   a_por_default: assert property (p_por_default) else $error("factory value missing");

   property p_block_temp;
      @(posedge CLK) disable iff (!RST_N)
         (wr_pend && wr_addr == `ACC_OFS_TEMP_OFFSET && !write_ok && !cal_tofs_done && por_done)
         |=> $stable(temp_coef);
   endproperty
   a_block_temp: assert property (p_block_temp) else $error("offset write not blocked");

   property p_block_cur;
      @(posedge CLK) disable iff (!RST_N)
         (wr_pend && wr_addr == `ACC_OFS_CUR_GAIN && state != acc_pkg::ACC_ST_IDLE
          && !cal_igain_done && por_done) |=> $stable(cur_coef);
   endproperty
   a_block_cur: assert property (p_block_cur) else $error("gain write not blocked");

   property p_write_temp;
      @(posedge CLK) disable iff (!RST_N)
         (wr_temp && por_done) |=> temp_coef == $past(HWDATA[15:0]);
   endproperty
   a_write_temp: assert property (p_write_temp) else $error("offset write lost");

   // The write gate trusts the idle timer, so the timer must restart whenever idle is left.
   property p_idle_time;
      @(posedge CLK) disable iff (!RST_N)
         !(state == acc_pkg::ACC_ST_IDLE && mode_reg[`ACC_MODE_ENABLE_BIT]
           && mode_field == acc_pkg::ACC_MODE_IDLE) |=> idle_cnt == 16'h0000;
   endproperty
   a_idle_time: assert property (p_idle_time) else $error("idle timer not restarted");

   property p_write_cur;
      @(posedge CLK) disable iff (!RST_N)
         (wr_cur && por_done) |=> ##1 CUR_GAIN_COEF == $past(HWDATA[15:0], 2);
   endproperty
   a_write_cur: assert property (p_write_cur) else $error("gain write lost");
endmodule

// *** testbench/acc_calib_regs_tb_top.sv ***
// Self-checking testbench for the calibration coefficient register block.
`timescale 1ns/10ps
`include "acc_consts.svh"
module acc_calib_regs_tb_top;
   localparam int IDLE_N = 10;
   localparam int CAL_N = 16;
   localparam logic [15:0] TOFS_DEF = 16'h8000;
   localparam logic [15:0] GAIN_DEF = 16'h5555;
   localparam logic [31:0] TOFS = `ACC_OFS_TEMP_OFFSET;
   localparam logic [31:0] GAIN = `ACC_OFS_CUR_GAIN;
   typedef struct packed {
      logic [31:0] mode;
      logic [7:0] gap;
      logic [31:0] addr;
      logic [31:0] data;
      logic [31:0] exp;
   } acc_row_type;
   // Offset rows go from refused writes to an accepted one and the gain refusal follows an accepted gain write, so each refusal leaves a known value.
   acc_row_type rows [6] = '{
      '{32'h0, 8'h14, TOFS, 32'h1234, 32'h8000},
      '{32'h3, 8'h14, TOFS, 32'h1234, 32'h8000},
      '{32'h1, 8'h02, TOFS, 32'h1234, 32'h8000},
      '{32'h1, 8'h14, TOFS, 32'hFFFF1234, 32'h1234},
      '{32'h1, 8'h00, GAIN, 32'hABCD, 32'hABCD},
      '{32'h0, 8'h14, GAIN, 32'h1111, 32'hABCD}};
   logic CLK, RST_N, HSEL, HWRITE;
   logic [31:0] HADDR, HWDATA, HRDATA, rd, prod;
   logic [1:0] HTRANS;
   logic [2:0] HSIZE;
   logic HREADYOUT, HRESP;
   wire logic HREADY;
   logic [15:0] TEMP_CAL_RESULT, CUR_CAL_RESULT, TEMP_RAW, CUR_RAW;
   logic [15:0] TEMP_OFFSET_COEF, CUR_GAIN_COEF, TEMP_CORRECTED, CUR_SCALED;
   int n_errors = 0;
   int checks = 0;
   assign HREADY = HREADYOUT;
   acc_calib_regs #(.IDLE_CYCLES(IDLE_N), .CAL_CYCLES(CAL_N), .TEMP_OFFSET_FACTORY(TOFS_DEF),
         .CUR_GAIN_FACTORY(GAIN_DEF)) u_acc_calib_regs (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL),
         .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
         .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
         .TEMP_CAL_RESULT(TEMP_CAL_RESULT), .CUR_CAL_RESULT(CUR_CAL_RESULT),
         .TEMP_RAW(TEMP_RAW), .CUR_RAW(CUR_RAW), .TEMP_OFFSET_COEF(TEMP_OFFSET_COEF),
         .CUR_GAIN_COEF(CUR_GAIN_COEF), .TEMP_CORRECTED(TEMP_CORRECTED),
         .CUR_SCALED(CUR_SCALED));
   initial begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Entered right after a rising edge; every signal changes by non-blocking assignment.
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
         output logic [31:0] rdat);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= a;
      HWRITE <= wr;
      HSIZE <= 3'h2;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      rdat = HRDATA;
      check("bus response", {31'h0, HRESP}, 32'h0);
   endtask
   task automatic do_reset;
      RST_N <= 1'b0;
      repeat (12) @(posedge CLK);
      check("coef in reset", {TEMP_OFFSET_COEF, CUR_GAIN_COEF}, 32'h0);
      RST_N <= 1'b1;
      repeat (3) @(posedge CLK);
      check("temp coef default", {16'h0, TEMP_OFFSET_COEF}, {16'h0, TOFS_DEF});
      check("gain coef default", {16'h0, CUR_GAIN_COEF}, {16'h0, GAIN_DEF});
      $display("test reset done");
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #50000;
      n_errors++;
      end_of_test();
   end
   initial begin
      RST_N = 1'b0;
      HSEL = 1'b0;
      HADDR = 32'h0;
      HTRANS = 2'h0;
      HWRITE = 1'b0;
      HSIZE = 3'h2;
      HWDATA = 32'h0;
      TEMP_CAL_RESULT = 16'h2468;
      CUR_CAL_RESULT = 16'h1357;
      TEMP_RAW = 16'h0;
      CUR_RAW = 16'h0;
      do_reset();
      bus(1'b0, TOFS, 32'h0, rd);
      check("temp coef read", rd, {16'h0, TOFS_DEF});
      bus(1'b0, GAIN, 32'h0, rd);
      check("gain coef read", rd, {16'h0, GAIN_DEF});
      bus(1'b0, 32'hFFFF0600, 32'h0, rd);
      check("unmapped read", rd, 32'h0);
      foreach (rows[i]) begin
         bus(1'b1, `ACC_OFS_MODE, rows[i].mode, rd);
         repeat (rows[i].gap) @(posedge CLK);
         bus(1'b1, rows[i].addr, rows[i].data, rd);
         bus(1'b0, rows[i].addr, 32'h0, rd);
         check("coef after write", rd, rows[i].exp);
         rd = (rows[i].addr == TOFS) ? {16'h0, TEMP_OFFSET_COEF} : {16'h0, CUR_GAIN_COEF};
         check("coef port", rd, rows[i].exp);
         $display("test row %0d done", i);
      end
      bus(1'b1, `ACC_OFS_MODE, 32'h1, rd);
      repeat (IDLE_N + 4) @(posedge CLK);
      for (int k = 0; k < 2; k++) begin
         // A write to the other coefficient while calibrating must be dropped.
         bus(1'b1, `ACC_OFS_MODE, (k == 0) ? 32'h5 : 32'h7, rd);
         bus(1'b1, (k == 0) ? GAIN : TOFS, 32'h0F0F, rd);
         repeat (CAL_N + 4) @(posedge CLK);
         bus(1'b0, `ACC_OFS_MODE, 32'h0, rd);
         check("mode after cal", rd, 32'h1);
         check("temp coef cal", {16'h0, TEMP_OFFSET_COEF}, 32'h2468);
         check("gain coef cal", {16'h0, CUR_GAIN_COEF}, (k == 0) ? 32'hABCD : 32'h1357);
         $display("test calibration %0d done", k);
      end
      TEMP_RAW <= 16'h1000;
      CUR_RAW <= 16'h4000;
      repeat (4) @(posedge CLK);
      rd = {16'h0, 16'h1000 - (16'h2468 - 16'h8000)};
      check("temp corrected", {16'h0, TEMP_CORRECTED}, rd);
      prod = 32'h4000 * 32'h1357;
      rd = ((prod >> 15) > 32'hFFFF) ? 32'hFFFF : (prod >> 15);
      check("current scaled", {16'h0, CUR_SCALED}, rd);
      $display("test datapath done");
      // By now the idle timer has run out and rests at its limit in the idle state.
      bus(1'b0, `ACC_OFS_STATUS, 32'h0, rd);
      check("status", rd, {16'h0, 13'(IDLE_N >> 3), 3'h1});
      $display("test status done");
      do_reset();
      end_of_test();
   end
endmodule
